// ==== hw/dual_mode_compare_timer_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// R1: Write-only control register, resets zero
// R2: Control bit 7 sets upper pin level
// R3: Bits 6-4 pick upper clock or cascade
// R4: Control bit 3 sets lower pin level
// R5: Bits 2-0 pick lower clock or event
// R6: Event edge polarity from edge select
// R7: Software avoids pin function switch while low
// R8: Status resets zero; flags only cleared
// R9: Flag clears only after read as one
// R10: Upper overflow flag on upper wrap
// R11: Upper match flag on upper compare equal
// R12: Status bit 5 enables upper overflow irq
// R13: Bit 4 clears on match, mode-dependent
// R14: Lower overflow flag on lower wrap
// R15: Lower match flag on lower compare equal
// R16: Status bit 1 enables lower overflow irq
// R17: Bit 0 clears lower counter on match
// R18: Holding byte for 16-bit byte access
// R19: CPU accesses upper byte first in 16-bit
// R20: Upper write to holding, lower commits both
// R21: Upper counter read latches lower byte
// R22: Compare reads are direct, no holding
// R23: Reset compares all ones, counters zero
// R24: 16-bit wrap sets upper overflow flag
// R25: Match signalled when counter leaves value
// R26: Flags with enables raise interrupt requests; here the match flags raise them with no enable
// R27: Control reads return all ones, harmless
// R28: Event input synchronised and edge detected
module dual_mode_compare_timer_ctrl
	import timer_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Peripheral byte bus
	input  wire logic [2:0] addr_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic [7:0] wdata_in,
	output logic      [7:0] rdata_out,
	// Event input
	input  wire logic       event_input_pin_in,
	input  wire logic       event_edge_select_in,
	// Toggle pins
	output logic            upper_toggle_pin_out,
	output logic            lower_toggle_pin_out,
	// Interrupt requests
	output logic            upper_irq_out,
	output logic            lower_irq_out
);

	timer_tick_if tif ();

	logic [7:0] ctrl_reg;
	logic [7:0] stat_reg;
	logic [7:0] seen_reg;
	logic [7:0] upper_cnt_reg;
	logic [7:0] lower_cnt_reg;
	logic [7:0] upper_cmp_reg;
	logic [7:0] lower_cmp_reg;
	logic [7:0] hold_reg;
	logic [7:0] rdata_reg;
	logic       upper_pin_reg;
	logic       lower_pin_reg;
	logic       upper_irq_reg;
	logic       lower_irq_reg;

	logic       mode16;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_ucnt;
	logic       wr_lcnt;
	logic       wr_ucmp;
	logic       wr_lcmp;
	logic       upper_wr_cnt;
	logic       upper_wr_cmp;
	logic       rd_stat;
	logic       rd_ucnt;
	logic       lower_tick;
	logic       lower_eq;
	logic       lower_match;
	logic       lower_clr;
	logic       lower_ovf;
	logic       full_match;
	logic       upper_step;
	logic       upper_match;
	logic       upper_clr;
	logic       upper_ovf;
	logic       lower_match_ev;
	logic       upper_match_ev;
	logic [7:0] flag_set;
	logic [7:0] rdata_next;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
		hit = (a == idx);
	endfunction

	timer_tick_source u_ticks (
		.clk_in               (clk_in),
		.rstn_in              (rstn_in),
		.event_input_pin_in   (event_input_pin_in),
		.event_edge_select_in (event_edge_select_in),
		.tif                  (tif.source)
	);

	assign mode16            = ~ctrl_reg[UPPER_SEL_MSB]; // R3
	assign tif.upper_int_sel = ctrl_reg[UPPER_SEL_MSB];
	assign tif.upper_rate    = ctrl_reg[UPPER_SEL_HI:UPPER_SEL_LO];
	assign tif.lower_int_sel = ctrl_reg[LOWER_SEL_MSB]; // R5
	assign tif.lower_rate    = ctrl_reg[LOWER_SEL_HI:LOWER_SEL_LO];
	assign lower_tick        = tif.lower_tick;

	// Bus decode
	assign wr_ctrl = wr_in & hit(addr_in, CTRL_IDX);
	assign wr_stat = wr_in & hit(addr_in, STAT_IDX);
	assign wr_ucnt = wr_in & hit(addr_in, UPPER_CNT_IDX);
	assign wr_lcnt = wr_in & hit(addr_in, LOWER_CNT_IDX);
	assign wr_ucmp = wr_in & hit(addr_in, UPPER_CMP_IDX);
	assign wr_lcmp = wr_in & hit(addr_in, LOWER_CMP_IDX);
	assign rd_stat = rd_in & hit(addr_in, STAT_IDX);
	assign rd_ucnt = rd_in & hit(addr_in, UPPER_CNT_IDX);

	// Writes that land on the upper byte in the current mode
	assign upper_wr_cnt = mode16 ? wr_lcnt : wr_ucnt;
	assign upper_wr_cmp = mode16 ? wr_lcmp : wr_ucmp;

	// Match fires on the tick that moves the counter off the value
	assign lower_eq    = (lower_cnt_reg == lower_cmp_reg);
	assign lower_match = lower_tick & lower_eq; // R25
	assign full_match  = lower_match & (upper_cnt_reg == upper_cmp_reg);
	assign lower_clr   = mode16 ? (full_match & stat_reg[UPPER_CCLR_BIT])
		: (lower_match & stat_reg[LOWER_CCLR_BIT]); // R13 R17
	assign lower_ovf   = lower_tick & ~lower_clr
		& (lower_cnt_reg == COUNT_MAX);
	assign upper_step  = mode16 ? lower_ovf : tif.upper_tick; // R3
	assign upper_match = mode16 ? full_match
		: (upper_step & (upper_cnt_reg == upper_cmp_reg)); // R25
	assign upper_clr   = upper_match & stat_reg[UPPER_CCLR_BIT]; // R13
	assign upper_ovf   = upper_step & ~upper_clr
		& (upper_cnt_reg == COUNT_MAX); // R24

	// A compare write in the same cycle inhibits that match
	assign lower_match_ev = lower_match & ~wr_lcmp;
	assign upper_match_ev = upper_match & ~upper_wr_cmp;

	// A counter write in the same cycle drops its overflow
	always_comb begin
		flag_set                  = 8'h00;
		flag_set[UPPER_OVF_BIT]   = upper_ovf & ~upper_wr_cnt; // R10 R24
		flag_set[UPPER_MATCH_BIT] = upper_match_ev; // R11
		flag_set[LOWER_OVF_BIT]   = lower_ovf & ~wr_lcnt; // R14
		flag_set[LOWER_MATCH_BIT] = lower_match_ev; // R15
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_reg <= CTRL_RESET; // R1
		end else if (wr_ctrl) begin
			ctrl_reg <= wdata_in;
		end
	end

	// Set beats a clear landing in the same cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stat_reg <= STAT_RESET; // R8
		end else begin
			for (int b = 0; b < 8; b++) begin
				if (FLAG_MASK[b]) begin
					stat_reg[b] <= flag_set[b] | (stat_reg[b]
						& ~(wr_stat & ~wdata_in[b] & seen_reg[b])); // R8 R9
				end else if (wr_stat) begin
					stat_reg[b] <= wdata_in[b]; // R12 R16
				end
			end
		end
	end

	// Remembers which flags software has seen set
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			seen_reg <= 8'h00;
		end else if (rd_stat) begin
			seen_reg <= stat_reg & FLAG_MASK; // R9
		end else if (wr_stat) begin
			seen_reg <= 8'h00;
		end
	end

	// Holding byte, used only in 16-bit mode
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_reg <= 8'h00;
		end else if (mode16 & (wr_ucnt | wr_ucmp)) begin
			hold_reg <= wdata_in; // R18 R20
		end else if (mode16 & rd_ucnt) begin
			hold_reg <= lower_cnt_reg; // R21
		end
	end

	// Bus writes win over counting
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lower_cnt_reg <= CNT_RESET; // R23
		end else if (wr_lcnt) begin
			lower_cnt_reg <= wdata_in;
		end else if (lower_clr) begin
			lower_cnt_reg <= CNT_RESET;
		end else if (lower_tick) begin
			lower_cnt_reg <= lower_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			upper_cnt_reg <= CNT_RESET; // R23
		end else if (mode16 & wr_lcnt) begin
			upper_cnt_reg <= hold_reg; // R20
		end else if (~mode16 & wr_ucnt) begin
			upper_cnt_reg <= wdata_in;
		end else if (upper_clr) begin
			upper_cnt_reg <= CNT_RESET; // R13
		end else if (upper_step) begin
			upper_cnt_reg <= upper_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			upper_cmp_reg <= CMP_RESET; // R23
			lower_cmp_reg <= CMP_RESET;
		end else begin
			if (mode16 & wr_lcmp) begin
				upper_cmp_reg <= hold_reg; // R20
			end else if (~mode16 & wr_ucmp) begin
				upper_cmp_reg <= wdata_in;
			end
			if (wr_lcmp) begin
				lower_cmp_reg <= wdata_in;
			end
		end
	end

	// Written level beats a toggle in the same cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			upper_pin_reg <= 1'b0;
			lower_pin_reg <= 1'b0;
		end else if (wr_ctrl) begin
			upper_pin_reg <= wdata_in[UPPER_LEVEL_BIT]; // R2
			lower_pin_reg <= wdata_in[LOWER_LEVEL_BIT]; // R4
		end else begin
			upper_pin_reg <= upper_pin_reg ^ upper_match_ev;
			lower_pin_reg <= lower_pin_reg ^ lower_match_ev;
		end
	end

	// Compare flags need no enable, overflow does
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			upper_irq_reg <= 1'b0;
			lower_irq_reg <= 1'b0;
		end else begin
			upper_irq_reg <= (stat_reg[UPPER_OVF_BIT]
				& stat_reg[UPPER_OVIE_BIT]) | stat_reg[UPPER_MATCH_BIT]; // R26
			lower_irq_reg <= (stat_reg[LOWER_OVF_BIT]
				& stat_reg[LOWER_OVIE_BIT]) | stat_reg[LOWER_MATCH_BIT]; // R26
		end
	end

	// Read data one cycle after the strobe
	always_comb begin
		unique case (addr_in)
			CTRL_IDX:      rdata_next = CTRL_READBACK; // R27
			STAT_IDX:      rdata_next = stat_reg;
			UPPER_CNT_IDX: rdata_next = upper_cnt_reg; // R21
			// Lower byte comes from the holding byte in 16-bit mode
			LOWER_CNT_IDX: rdata_next = mode16 ? hold_reg
				: lower_cnt_reg; // R21
			UPPER_CMP_IDX: rdata_next = upper_cmp_reg; // R22
			LOWER_CMP_IDX: rdata_next = lower_cmp_reg; // R22
			default:       rdata_next = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_reg <= 8'h00;
		end else if (rd_in) begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_out            = rdata_reg;
	assign upper_toggle_pin_out = upper_pin_reg;
	assign lower_toggle_pin_out = lower_pin_reg;
	assign upper_irq_out        = upper_irq_reg;
	assign lower_irq_out        = lower_irq_reg;

endmodule

// ==== common/timer_pkg.sv ====
package timer_pkg;

	// Register indices on the 8-bit peripheral bus
	localparam logic [2:0] CTRL_IDX      = 3'h0;
	localparam logic [2:0] STAT_IDX      = 3'h1;
	localparam logic [2:0] UPPER_CNT_IDX = 3'h2;
	localparam logic [2:0] LOWER_CNT_IDX = 3'h3;
	localparam logic [2:0] UPPER_CMP_IDX = 3'h4;
	localparam logic [2:0] LOWER_CMP_IDX = 3'h5;

	// Reset values, fixed read values and count limit
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] STAT_RESET    = 8'h00;
	localparam logic [7:0] CNT_RESET     = 8'h00;
	localparam logic [7:0] CMP_RESET     = 8'hff;
	localparam logic [7:0] CTRL_READBACK = 8'hff;
	localparam logic [7:0] UNMAPPED_READ = 8'hff;
	localparam logic [7:0] COUNT_MAX     = 8'hff;

	// Control field positions
	localparam int UPPER_LEVEL_BIT = 7;
	localparam int UPPER_SEL_MSB   = 6;
	localparam int UPPER_SEL_HI    = 5;
	localparam int UPPER_SEL_LO    = 4;
	localparam int LOWER_LEVEL_BIT = 3;
	localparam int LOWER_SEL_MSB   = 2;
	localparam int LOWER_SEL_HI    = 1;
	localparam int LOWER_SEL_LO    = 0;

	// Status field positions
	localparam int UPPER_OVF_BIT   = 7;
	localparam int UPPER_MATCH_BIT = 6;
	localparam int UPPER_OVIE_BIT  = 5;
	localparam int UPPER_CCLR_BIT  = 4;
	localparam int LOWER_OVF_BIT   = 3;
	localparam int LOWER_MATCH_BIT = 2;
	localparam int LOWER_OVIE_BIT  = 1;
	localparam int LOWER_CCLR_BIT  = 0;
	localparam logic [7:0] FLAG_MASK = 8'hcc;

	// Prescaler rate codes
	localparam int          PRESCALE_W = 5;
	localparam logic [1:0]  RATE_DIV32 = 2'h0;
	localparam logic [1:0]  RATE_DIV16 = 2'h1;
	localparam logic [1:0]  RATE_DIV4  = 2'h2;
	localparam logic [1:0]  RATE_DIV2  = 2'h3;

endpackage

// ==== common/timer_tick_if.sv ====
`timescale 1ns/1ps
interface timer_tick_if;
	logic       upper_int_sel;
	logic [1:0] upper_rate;
	logic       lower_int_sel;
	logic [1:0] lower_rate;
	logic       upper_tick;
	logic       lower_tick;

	modport core (
		output upper_int_sel, upper_rate, lower_int_sel, lower_rate,
		input  upper_tick, lower_tick
	);
	modport source (
		input  upper_int_sel, upper_rate, lower_int_sel, lower_rate,
		output upper_tick, lower_tick
	);
endinterface

// ==== hw/timer_tick_source.sv ====
`timescale 1ns/1ps
module timer_tick_source
	import timer_pkg::*;
(
	// Clock and reset
	input  wire logic     clk_in,
	input  wire logic     rstn_in,
	// Event pin and edge choice
	input  wire logic     event_input_pin_in,
	input  wire logic     event_edge_select_in,
	// Tick carrier
	timer_tick_if.source  tif
);

	logic [PRESCALE_W-1:0] div_reg;
	logic                  sync1_reg;
	logic                  sync2_reg;
	logic                  last_reg;
	logic                  event_edge;

	function automatic logic rate_tick(input logic [1:0] rate,
		input logic [PRESCALE_W-1:0] cnt);
		unique case (rate)
			RATE_DIV32: rate_tick = &cnt[4:0];
			RATE_DIV16: rate_tick = &cnt[3:0];
			RATE_DIV4:  rate_tick = &cnt[1:0];
			RATE_DIV2:  rate_tick = cnt[0];
		endcase
	endfunction

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// Pin is asynchronous to us; first stage feeds only the second
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			last_reg  <= 1'b0;
		end else begin
			sync1_reg <= event_input_pin_in; // R28
			sync2_reg <= sync1_reg;
			last_reg  <= sync2_reg;
		end
	end

	// High selects rising edges, low falling
	assign event_edge = event_edge_select_in ? (sync2_reg & ~last_reg)
		: (~sync2_reg & last_reg); // R6

	assign tif.lower_tick = tif.lower_int_sel
		? rate_tick(tif.lower_rate, div_reg) : event_edge; // R5
	assign tif.upper_tick = tif.upper_int_sel
		& rate_tick(tif.upper_rate, div_reg); // R3

endmodule

// ==== testbench/timer_ctrl_assertions.sv ====
`timescale 1ns/1ps
module timer_ctrl_assertions
	import timer_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Byte bus
	input  wire logic [2:0] addr_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic [7:0] rdata_out,
	// Pins and requests
	input  wire logic       event_input_pin_in,
	input  wire logic       event_edge_select_in,
	input  wire logic       upper_toggle_pin_out,
	input  wire logic       lower_toggle_pin_out,
	input  wire logic       upper_irq_out,
	input  wire logic       lower_irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	logic [7:0] en_reg;
	logic       ctrl_wr_reg;

	// Enables mirrored so flag activity cannot hide a lost write
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			en_reg <= 8'h00;
		end else if (wr_in && addr_in == STAT_IDX) begin
			en_reg <= wdata_in & ~FLAG_MASK;
		end
	end

	// A pin change right after a control write is no match
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_wr_reg <= 1'b0;
		end else begin
			ctrl_wr_reg <= wr_in && addr_in == CTRL_IDX;
		end
	end

	sequence ctrl_write;
		wr_in && addr_in == CTRL_IDX;
	endsequence

	ctrl_reads_ones_a: assert property (
		rd_in && addr_in == CTRL_IDX |=> rdata_out == CTRL_READBACK)
		else $error("control read not all ones");
	unmapped_reads_a: assert property (
		rd_in && addr_in > LOWER_CMP_IDX |=> rdata_out == UNMAPPED_READ)
		else $error("unmapped read not all ones");
	rdata_holds_a: assert property (!rd_in |=> $stable(rdata_out))
		else $error("read data moved without a read");
	upper_level_a: assert property (
		ctrl_write |=> upper_toggle_pin_out == $past(wdata_in[7]))
		else $error("upper pin level not taken");
	lower_level_a: assert property (
		ctrl_write |=> lower_toggle_pin_out == $past(wdata_in[3]))
		else $error("lower pin level not taken");
	enable_readback_a: assert property (
		rd_in && addr_in == STAT_IDX |=> (rdata_out & ~FLAG_MASK) == en_reg)
		else $error("status enables not as written");
	lower_match_irq_a: assert property (
		$changed(lower_toggle_pin_out) && !ctrl_wr_reg |=> lower_irq_out)
		else $error("lower match without request");
	upper_match_irq_a: assert property (
		$changed(upper_toggle_pin_out) && !ctrl_wr_reg |=> upper_irq_out)
		else $error("upper match without request");
endmodule

bind dual_mode_compare_timer_ctrl timer_ctrl_assertions chk (
	.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
	.wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
	.rdata_out(rdata_out), .event_input_pin_in(event_input_pin_in),
	.event_edge_select_in(event_edge_select_in),
	.upper_toggle_pin_out(upper_toggle_pin_out),
	.lower_toggle_pin_out(lower_toggle_pin_out),
	.upper_irq_out(upper_irq_out), .lower_irq_out(lower_irq_out));

// ==== testbench/cpu_bus_model.sv ====
`timescale 1ns/1ps
module cpu_bus_model (
	// Clock
	input  wire logic       clk_in,
	// Byte bus toward the timer
	output logic      [2:0] addr_out,
	output logic            wr_out,
	output logic            rd_out,
	output logic      [7:0] wdata_out,
	input  wire logic [7:0] rdata_in
);
	initial begin
		addr_out = 3'h0;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end

	task automatic put(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask

	task automatic get(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(negedge clk_in);
		d = rdata_in;
	endtask

	// Upper byte first, else the holding byte pairs wrongly
	task automatic put16(input logic [2:0] a, input logic [15:0] v);
		put(a, v[15:8]);
		put(a + 3'h1, v[7:0]);
	endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	import timer_pkg::*;
	logic       clk_in = 1'b0;
	logic       rstn_in = 1'b0;
	logic       ev_pin = 1'b0;
	logic       ev_sel = 1'b0;
	logic [2:0] addr;
	logic       wr, rd, up_pin, lo_pin, up_irq, lo_irq;
	logic [7:0] wdata, rdata;
	int         failures = 0;
	int         tests_run = 0;

	always #12.5 clk_in = ~clk_in;

	cpu_bus_model cpu (.clk_in(clk_in), .addr_out(addr), .wr_out(wr),
		.rd_out(rd), .wdata_out(wdata), .rdata_in(rdata));
	dual_mode_compare_timer_ctrl DUT (.clk_in(clk_in), .rstn_in(rstn_in),
		.addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wdata),
		.rdata_out(rdata), .event_input_pin_in(ev_pin),
		.event_edge_select_in(ev_sel), .upper_toggle_pin_out(up_pin),
		.lower_toggle_pin_out(lo_pin), .upper_irq_out(up_irq),
		.lower_irq_out(lo_irq));

	task conclude;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task expect_rd(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		cpu.get(a, d);
		check(d, exp);
	endtask

	// Bounded so a dead interrupt path cannot hang the run
	task wait_irq(input logic upper, input int lim);
		int n;
		n = 0;
		while ((upper ? up_irq : lo_irq) !== 1'b1 && n < lim) begin
			@(negedge clk_in);
			n++;
		end
		if ((upper ? up_irq : lo_irq) !== 1'b1) begin
			failures++;
			$display("Error %0t: request wait ran out", $time);
			conclude();
		end
	endtask

	task pulse(input int n);
		repeat (n) begin
			@(posedge clk_in) ev_pin <= 1'b1;
			repeat (4) @(posedge clk_in);
			ev_pin <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
	endtask

	task reset_values;
		expect_rd(CTRL_IDX, CTRL_READBACK);
		expect_rd(STAT_IDX, 8'h00);
		expect_rd(UPPER_CNT_IDX, 8'h00);
		expect_rd(LOWER_CNT_IDX, 8'h00);
		expect_rd(UPPER_CMP_IDX, 8'hff);
		expect_rd(LOWER_CMP_IDX, 8'hff);
		expect_rd(3'h6, UNMAPPED_READ);
	endtask

	task wide_access;
		cpu.put16(UPPER_CNT_IDX, 16'haa55);
		cpu.put(UPPER_CNT_IDX, 8'h12);
		expect_rd(UPPER_CNT_IDX, 8'haa);
		expect_rd(LOWER_CNT_IDX, 8'h55);
		cpu.put16(UPPER_CMP_IDX, 16'h1234);
		expect_rd(UPPER_CMP_IDX, 8'h12);
		expect_rd(LOWER_CMP_IDX, 8'h34);
	endtask

	task event_count;
		cpu.put16(UPPER_CNT_IDX, 16'h0000);
		ev_sel <= 1'b1;
		pulse(3);
		expect_rd(UPPER_CNT_IDX, 8'h00);
		expect_rd(LOWER_CNT_IDX, 8'h03);
		// Edge choice changes only while the pin rests low
		ev_sel <= 1'b0;
		pulse(2);
		expect_rd(UPPER_CNT_IDX, 8'h00);
		expect_rd(LOWER_CNT_IDX, 8'h05);
	endtask

	task flags_and_irq;
		cpu.put16(UPPER_CMP_IDX, 16'hffff);
		cpu.put16(UPPER_CNT_IDX, 16'h0000);
		cpu.put(CTRL_IDX, 8'h47);
		wait_irq(1'b0, 1000);
		check({7'h0, lo_pin}, 8'h01);
		cpu.put(CTRL_IDX, 8'h40);
		cpu.put(STAT_IDX, 8'h00);
		expect_rd(STAT_IDX, 8'h0c);
		cpu.put(STAT_IDX, 8'h22);
		expect_rd(STAT_IDX, 8'h22);
		cpu.put(STAT_IDX, 8'hee);
		expect_rd(STAT_IDX, 8'h22);
		check({7'h0, lo_irq}, 8'h00);
		wait_irq(1'b1, 9000);
		check({7'h0, up_pin}, 8'h01);
		expect_rd(STAT_IDX, 8'he2);
	endtask

	task wide_match;
		logic [7:0] d;
		cpu.put(STAT_IDX, 8'h10);
		cpu.put(CTRL_IDX, 8'h05);
		cpu.put16(UPPER_CNT_IDX, 16'h0100);
		cpu.put16(UPPER_CMP_IDX, 16'h0105);
		wait_irq(1'b1, 300);
		expect_rd(UPPER_CNT_IDX, 8'h00);
		expect_rd(STAT_IDX, 8'h54);
		cpu.put(STAT_IDX, 8'h20);
		cpu.put16(UPPER_CNT_IDX, 16'hfff0);
		wait_irq(1'b1, 400);
		expect_rd(STAT_IDX, 8'ha8);
		cpu.put(CTRL_IDX, 8'h40);
		cpu.put(LOWER_CNT_IDX, 8'h00);
		cpu.put(LOWER_CMP_IDX, 8'h03);
		cpu.put(STAT_IDX, 8'h01);
		cpu.put(CTRL_IDX, 8'h46);
		wait_irq(1'b0, 100);
		cpu.get(LOWER_CNT_IDX, d);
		check(d & 8'hfc, 8'h00);
	endtask

	initial begin
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'b1;
		reset_values();
		wide_access();
		event_count();
		flags_and_irq();
		wide_match();
		conclude();
	end
endmodule
